// ==== core/hpw_pkg.sv ====
// constants and carrier types for the high-resolution pulse-width channel
// assumes one 10 MHz clock, with each clock standing for one fast-clock count
package hpw_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_PS       = 250;
  localparam int PHASES        = 16;
  localparam int SUB_W         = $clog2(PHASES);
  localparam int CNT_W         = 14;
  localparam int POS_W         = CNT_W + SUB_W;
  localparam int DUTY_W        = 24;
  localparam int ADJ_STEPS     = 32768;
  localparam int ADJ_W         = $clog2(ADJ_STEPS) + 1;
  localparam int CTL_DIV       = 4;
  localparam int CTL_SHIFT     = $clog2(CTL_DIV);
  localparam int SAMP_W        = CNT_W - CTL_SHIFT;
  localparam int RATIO_W       = 8;
  localparam int OS_W          = 2;
  localparam logic [CTL_SHIFT-1:0] CTL_LAST = 2'h3;
  localparam logic [CNT_W-1:0]     CNT_RST  = 14'h0000;
  localparam logic [RATIO_W-1:0]   DIV_RST  = 8'h00;

  // software settings of one channel
  typedef struct packed {
    logic [CNT_W-1:0]        period;
    logic [CNT_W-1:0]        event1;
    logic [POS_W-1:0]        event2;
    logic [POS_W-1:0]        event3;
    logic [POS_W-1:0]        event4;
    logic signed [ADJ_W-1:0] adj_a;
    logic signed [ADJ_W-1:0] adj_b;
    logic [SAMP_W-1:0]       samp1;
    logic [SAMP_W-1:0]       samp2;
    logic [CNT_W-1:0]        phase;
    logic [CNT_W-1:0]        blank_a_begin;
    logic [CNT_W-1:0]        blank_a_end;
    logic [CNT_W-1:0]        blank_b_begin;
    logic [CNT_W-1:0]        blank_b_end;
    logic                    pol_low_a;
    logic                    pol_low_b;
    logic                    open_loop;
    logic [OS_W-1:0]         oversample;
    logic [RATIO_W-1:0]      irq_ratio;
  } hpw_cfg_t;

  // state of the channel core, apart from the period divider
  typedef struct packed {
    logic [CNT_W-1:0]     cnt;
    logic [CNT_W-1:0]     period;
    logic [DUTY_W-2:0]    duty;
    logic [DUTY_W-2:0]    duty_live;
    logic [CTL_SHIFT-1:0] ctl_div;
    logic [2:0]           os_left;
    logic [CNT_W-1:0]     os_cnt;
    logic                 act_a;
    logic                 act_b;
    logic                 pin_a;
    logic                 pin_b;
    logic [SUB_W-1:0]     sub_a;
    logic [SUB_W-1:0]     sub_b;
    logic                 sync_out;
    logic                 samp_trig;
    logic                 samp_trig2;
    logic                 blank_a;
    logic                 blank_b;
    logic                 period_end;
  } hpw_state_t;

  // state of the period divider
  typedef struct packed {
    logic [RATIO_W-1:0] cnt;
    logic               pulse;
  } hpw_div_state_t;

endpackage

// ==== core/hpw_period_div.sv ====
// divides the end-of-period pulse by a programmable ratio
// assumes tick is a one-cycle pulse on ref_clk
`timescale 1ns/1ns
module hpw_period_div
  import hpw_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               tick,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    pulse
);

  hpw_div_state_t st;
  hpw_div_state_t next_st;

  // ratio n gives one pulse every n+1 periods
  always_comb
  begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (tick)
    begin
      if (st.cnt >= ratio)
      begin
        next_st.cnt = DIV_RST;
        next_st.pulse = 1'b1;
      end
      else
      begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign pulse = st.pulse;

endmodule

// ==== core/hpw_channel.sv ====
// high-resolution pulse-width channel: time base, edges, sync, sampling, blanking
// assumes inputs synchronous to ref_clk; a phase-select delay line after this
// block shifts each pin edge by the sub-step shown beside it
`timescale 1ns/1ns
module hpw_channel
  import hpw_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire hpw_cfg_t                 cfg,
  input  wire logic signed [DUTY_W-1:0] duty,
  input  wire logic                     duty_valid,
  input  wire logic                     sync_in,
  output logic                          output_a,
  output logic                          output_b,
  output logic [SUB_W-1:0]              sub_a,
  output logic [SUB_W-1:0]              sub_b,
  output logic                          sync_out,
  output logic                          sample_trig,
  output logic                          sample_trig2,
  output logic                          blank_a,
  output logic                          blank_b,
  output logic                          period_end,
  output logic                          irq,
  output logic                          gp_conv_start
);

  // a single step is 1/PHASES of a clock; the phase taps give the sub-step
  localparam int STEPS_PER_CLK = PHASES;
  localparam int PROD_W        = (DUTY_W - 1) + POS_W;

  hpw_state_t st;
  hpw_state_t next_st;

  // add a signed step adjust to a step position, clamping below zero
  function automatic logic [POS_W-1:0] add_adj(input logic [POS_W-1:0] pos,
                                               input logic signed [ADJ_W-1:0] adj);
    logic signed [POS_W+1:0] sum;
    sum = $signed({2'b00, pos}) + (POS_W+2)'(adj);
    if (sum < 0)
      add_adj = '0;
    else
      add_adj = sum[POS_W-1:0];
  endfunction

  // control-clock units are four fast counts
  function automatic logic [CNT_W-1:0] ctl_to_cnt(input logic [SAMP_W-1:0] v);
    ctl_to_cnt = {v, {CTL_SHIFT{1'b0}}};
  endfunction

  logic                    ctl_en;
  logic                    wrap;
  logic [PROD_W-1:0]       prod;
  logic [POS_W-1:0]        on_steps;
  logic [POS_W-1:0]        closed_fall;
  logic [POS_W-1:0]        fall_a;
  logic [POS_W-1:0]        rise_b;
  logic [POS_W-1:0]        fall_b;
  logic [CNT_W-1:0]        os_int;
  logic [CNT_W-1:0]        os_raw;
  logic [2:0]              os_extra;

  // quarter-rate control clock as an enable
  assign ctl_en = (st.ctl_div == CTL_LAST);
  assign wrap   = (st.cnt >= st.period);

  // on-time in 250 ps steps is duty times the period in steps
  assign prod        = st.duty * {st.period, {SUB_W{1'b0}}};
  assign on_steps    = prod[PROD_W-1:DUTY_W-1];
  assign closed_fall = {cfg.event1, {SUB_W{1'b0}}} + on_steps;

  // open loop ignores the filter entirely
  assign fall_a = add_adj(cfg.open_loop ? cfg.event2 : closed_fall, cfg.adj_a);
  assign rise_b = cfg.event3;
  assign fall_b = add_adj(cfg.event4, cfg.adj_b);

  // oversample spacing is the period divided by 1, 2, 4 or 8
  assign os_raw   = st.period >> cfg.oversample;
  assign os_int   = (os_raw == CNT_RST) ? 14'h0001 : os_raw;
  assign os_extra = 3'((4'h1 << cfg.oversample) - 4'h1);

  always_comb
  begin
    next_st = st;
    next_st.ctl_div    = st.ctl_div + 2'h1;
    next_st.period_end = 1'b0;
    next_st.samp_trig  = 1'b0;
    next_st.samp_trig2 = 1'b0;

    // duty is taken on the control clock; negative values clamp to zero
    if (duty_valid && ctl_en)
      next_st.duty_live = duty[DUTY_W-1] ? '0 : duty[DUTY_W-2:0];

    // time base: sync reset, otherwise wrap at the active period
    if (sync_in)
    begin
      next_st.cnt = CNT_RST;
    end
    else if (wrap)
    begin
      next_st.cnt        = CNT_RST;
      next_st.period     = cfg.period;
      next_st.duty       = st.duty_live;
      next_st.period_end = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 14'h0001;
    end

    // output A: whole-clock rise, fall carries its sub-step
    if (st.cnt == cfg.event1)
    begin
      next_st.act_a = 1'b1;
      next_st.sub_a = '0;
    end
    if (st.cnt == fall_a[POS_W-1:SUB_W])
    begin
      next_st.act_a = 1'b0;
      next_st.sub_a = fall_a[SUB_W-1:0];
    end

    // output B: both edges carry sub-steps
    if (st.cnt == rise_b[POS_W-1:SUB_W])
    begin
      next_st.act_b = 1'b1;
      next_st.sub_b = rise_b[SUB_W-1:0];
    end
    if (st.cnt == fall_b[POS_W-1:SUB_W])
    begin
      next_st.act_b = 1'b0;
      next_st.sub_b = fall_b[SUB_W-1:0];
    end

    // pins are registered with polarity applied
    next_st.pin_a = next_st.act_a ^ cfg.pol_low_a;
    next_st.pin_b = next_st.act_b ^ cfg.pol_low_b;

    // phase threshold drives the slave sync
    next_st.sync_out = (st.cnt == cfg.phase);

    // blanking windows straight from settings, in any mode
    if (st.cnt == cfg.blank_a_begin)
      next_st.blank_a = 1'b1;
    if (st.cnt == cfg.blank_a_end)
      next_st.blank_a = 1'b0;
    if (st.cnt == cfg.blank_b_begin)
      next_st.blank_b = 1'b1;
    if (st.cnt == cfg.blank_b_end)
      next_st.blank_b = 1'b0;

    // first trigger at the sample count, then evenly spaced extras
    if (st.cnt == ctl_to_cnt(cfg.samp1))
    begin
      next_st.samp_trig = 1'b1;
      next_st.os_left   = os_extra;
      next_st.os_cnt    = 14'h0001;
    end
    else if (st.os_left != 3'h0)
    begin
      if (st.os_cnt >= os_int)
      begin
        next_st.samp_trig = 1'b1;
        next_st.os_left   = st.os_left - 3'h1;
        next_st.os_cnt    = 14'h0001;
      end
      else
      begin
        next_st.os_cnt = st.os_cnt + 14'h0001;
      end
    end
    next_st.samp_trig2 = (st.cnt == ctl_to_cnt(cfg.samp2));
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  // interrupt and converter start share the divided period event
  hpw_period_div u_div (
    .ref_clk (ref_clk),
    .srst    (srst),
    .tick    (st.period_end),
    .ratio   (cfg.irq_ratio),
    .pulse   (irq)
  );

  assign gp_conv_start = irq;
  assign output_a      = st.pin_a;
  assign output_b      = st.pin_b;
  assign sub_a         = st.sub_a;
  assign sub_b         = st.sub_b;
  assign sync_out      = st.sync_out;
  assign sample_trig   = st.samp_trig;
  assign sample_trig2  = st.samp_trig2;
  assign blank_a       = st.blank_a;
  assign blank_b       = st.blank_b;
  assign period_end    = st.period_end;

  // helpers read only by the checks below
  logic [CNT_W-1:0]  shadow_q;
  logic [SUB_W-1:0]  fall_a_sub;
  logic              fall_a_hit;
  logic [SUB_W-1:0]  rise_b_sub;
  logic [SUB_W-1:0]  fall_b_sub;
  logic              fall_b_hit;
  logic [DUTY_W-2:0] duty_mag;
  logic              samp1_hit;
  assign fall_a_sub = fall_a[SUB_W-1:0];
  assign fall_a_hit = (st.cnt == fall_a[POS_W-1:SUB_W]);
  // a same-count rise and fall on B is a zero-width pulse, so rise checks skip it
  assign rise_b_sub = rise_b[SUB_W-1:0];
  assign fall_b_sub = fall_b[SUB_W-1:0];
  assign fall_b_hit = (st.cnt == fall_b[POS_W-1:SUB_W]);
  assign duty_mag   = duty[DUTY_W-2:0];
  assign samp1_hit  = (st.cnt == ctl_to_cnt(cfg.samp1));
  always_ff @(posedge ref_clk)
  begin
    shadow_q <= cfg.period;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_ctl_gap;
    !ctl_en [*3] ##1 ctl_en;
  endsequence

  sequence s_blank_a_open;
    (st.cnt == cfg.blank_a_begin) && (st.cnt != cfg.blank_a_end) ##1 st.blank_a;
  endsequence

  a_sync_clears_count: assert property (sync_in |=> st.cnt == CNT_RST)
    else $error("sync did not clear the counter");
  a_wrap_loads_shadow: assert property ((wrap && !sync_in) |=>
    (st.cnt == CNT_RST) && (st.period == shadow_q) && st.period_end)
    else $error("period end did not load the shadow");
  a_period_held: assert property (!wrap && !sync_in && !$past(srst) |=> $stable(st.period))
    else $error("active period changed mid period");
  a_rise_a_whole: assert property ((st.cnt == cfg.event1) && !fall_a_hit |=>
    st.act_a && (st.sub_a == '0))
    else $error("output A did not rise at event 1");
  a_fall_a_sub: assert property (fall_a_hit |=>
    !st.act_a && (st.sub_a == $past(fall_a_sub)))
    else $error("output A fall or sub-step wrong");
  a_sync_out_phase: assert property ((st.cnt == cfg.phase) |=> st.sync_out)
    else $error("sync output missed the phase count");
  a_sample_hit: assert property ((st.cnt == ctl_to_cnt(cfg.samp1)) |=> st.samp_trig)
    else $error("sample trigger missed");
  a_ctl_quarter: assert property (ctl_en |=> s_ctl_gap)
    else $error("control enable not one in four");
  a_blank_a_window: assert property ((st.cnt == cfg.blank_a_begin) &&
    (st.cnt != cfg.blank_a_end) |-> s_blank_a_open)
    else $error("blanking A did not open");
  a_pin_polarity: assert property ($rose(st.act_a) && $stable(cfg.pol_low_a) |->
    (st.pin_a != cfg.pol_low_a))
    else $error("output A polarity wrong");

  // output B edges and polarity mirror output A, except that the B rise also carries a sub-step
  a_rise_b_sub: assert property ((st.cnt == rise_b[POS_W-1:SUB_W]) && !fall_b_hit |=>
    st.act_b && (st.sub_b == $past(rise_b_sub)))
    else $error("output B rise or sub-step wrong");
  a_fall_b_sub: assert property (fall_b_hit |=>
    !st.act_b && (st.sub_b == $past(fall_b_sub)))
    else $error("output B fall or sub-step wrong");
  a_pin_b_polarity: assert property ($rose(st.act_b) && $stable(cfg.pol_low_b) |->
    (st.pin_b != cfg.pol_low_b))
    else $error("output B polarity wrong");

  // blanking windows close at their end count, which wins a tie
  a_blank_b_window: assert property ((st.cnt == cfg.blank_b_begin) &&
    (st.cnt != cfg.blank_b_end) |=> st.blank_b)
    else $error("blanking B did not open");
  a_blank_a_close: assert property ((st.cnt == cfg.blank_a_end) |=> !st.blank_a)
    else $error("blanking A did not close");
  a_blank_b_close: assert property ((st.cnt == cfg.blank_b_end) |=> !st.blank_b)
    else $error("blanking B did not close");

  // second sample trigger is a single pulse at its own count, never oversampled
  a_sample2_hit: assert property ((st.cnt == ctl_to_cnt(cfg.samp2)) |=> st.samp_trig2)
    else $error("second sample trigger missed");
  a_sample2_only: assert property ((st.cnt != ctl_to_cnt(cfg.samp2)) |=> !st.samp_trig2)
    else $error("second sample trigger out of place");

  // oversampling: the first hit arms the extras, each spaced by os_int
  a_os_armed: assert property (samp1_hit |=> (st.os_left == $past(os_extra)))
    else $error("oversample count not armed");
  a_os_extra: assert property (!samp1_hit && (st.os_left != 3'h0) &&
    (st.os_cnt >= os_int) |=> st.samp_trig)
    else $error("oversample trigger missed");

  // sync wins over the period end: no pulse and no shadow load
  a_sync_no_wrap: assert property (sync_in |=> !st.period_end && $stable(st.period))
    else $error("sync let the period end through");
  a_count_step: assert property (!sync_in && !wrap |=>
    (st.cnt == $past(st.cnt) + 14'h0001))
    else $error("time base did not count");
  a_period_end_zero: assert property (st.period_end |-> (st.cnt == CNT_RST))
    else $error("period end without a counter restart");
  a_sync_out_only: assert property ((st.cnt != cfg.phase) |=> !st.sync_out)
    else $error("sync output out of place");

  // duty is taken only on the control clock; a negative value clamps to zero
  a_duty_clamp: assert property (duty_valid && ctl_en && duty[DUTY_W-1] |=>
    (st.duty_live == '0))
    else $error("negative duty not clamped");
  a_duty_taken: assert property (duty_valid && ctl_en && !duty[DUTY_W-1] |=>
    (st.duty_live == $past(duty_mag)))
    else $error("duty not taken");
  a_duty_held: assert property (!(duty_valid && ctl_en) |=> $stable(st.duty_live))
    else $error("duty taken off the control clock");

  // the divided interrupt always follows a period end by one cycle
  a_irq_after_end: assert property (irq |-> $past(st.period_end))
    else $error("interrupt without a period end");

endmodule

// ==== bench/hpw_stage_model.sv ====
// behavioural far side: error converter front end and loop filter feeding duty
// assumes sample_trig is a one-cycle pulse on ref_clk; duty_cmd set by the bench
`timescale 1ns/1ns
module hpw_stage_model
  import hpw_pkg::*;
(
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic                     sample_trig,
  input  wire logic signed [DUTY_W-1:0] duty_cmd,
  output logic signed [DUTY_W-1:0]      duty,
  output logic                          duty_valid
);
  logic [3:0] wait_cnt;

  // conversion and filter delay, then valid held over one quarter-rate slot
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      wait_cnt   <= 4'h0;
      duty_valid <= 1'b0;
      duty       <= '0;
    end
    else if (sample_trig)
      wait_cnt <= 4'h6;
    else if (wait_cnt != 4'h0)
    begin
      wait_cnt   <= wait_cnt - 4'h1;
      duty_valid <= (wait_cnt <= 4'h4);
      duty       <= (wait_cnt <= 4'h4) ? duty_cmd : ~duty;
    end
    else
    begin
      duty_valid <= 1'b0;
      duty       <= ~duty; // idle bus toggles so a stale value is never taken
    end
  end
endmodule

// ==== bench/test_hpw_channel.sv ====
// self-checking bench for the pulse-width channel, one task per scenario
// assumes the channel core, its package and the behavioural far-side model
`timescale 1ns/1ns
module test_hpw_channel;
  import hpw_pkg::*;
  localparam int DLY = 10;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic sync_in = 1'b0;
  hpw_cfg_t cfg = '0;
  logic signed [DUTY_W-1:0] duty_cmd = 24'h000000;
  logic signed [DUTY_W-1:0] duty;
  logic duty_valid, output_a, output_b, sync_out, sample_trig, sample_trig2;
  logic blank_a, blank_b, period_end, irq, gp_conv_start;
  logic [SUB_W-1:0] sub_a, sub_b;
  int err_total = 0;
  int total_checks = 0;

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  hpw_channel dut (.ref_clk(ref_clk), .srst(srst), .cfg(cfg), .duty(duty),
    .duty_valid(duty_valid), .sync_in(sync_in), .output_a(output_a),
    .output_b(output_b), .sub_a(sub_a), .sub_b(sub_b), .sync_out(sync_out),
    .sample_trig(sample_trig), .sample_trig2(sample_trig2), .blank_a(blank_a),
    .blank_b(blank_b), .period_end(period_end), .irq(irq),
    .gp_conv_start(gp_conv_start));
  hpw_stage_model far_side (.ref_clk(ref_clk), .srst(srst), .sample_trig(sample_trig),
    .duty_cmd(duty_cmd), .duty(duty), .duty_valid(duty_valid));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input bit ok, input string msg);
    total_checks++;
    if (!ok)
    begin
      err_total++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return output_a;
      1: return output_b;
      2: return sync_out;
      3: return sample_trig;
      4: return sample_trig2;
      5: return blank_a;
      6: return period_end;
      7: return irq;
      8: return blank_b;
      default: return 1'b0;
    endcase
  endfunction

  // edges until the watched signal is high; exp_n below 0 only synchronises
  task automatic gap(input int w, input int exp_n);
    int n;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      #DLY;
      n++;
    end
    while (sig(w) !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      err_total++;
      $display("FAIL %0t wait ran out", $time);
      wrap_up();
    end
    if (exp_n >= 0)
      chk(n == exp_n, $sformatf("signal %0d after %0d cycles", w, n));
  endtask

  // cycles with the watched signal high over a window
  task automatic tally(input int w, input int len, output int n);
    n = 0;
    repeat (len)
    begin
      @(posedge ref_clk);
      #DLY;
      n += (sig(w) === 1'b1);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #DLY;
  endtask

  // period length and shadowed period update
  task automatic t_period();
    cfg.period = 14'h0009;
    gap(6, -1);
    gap(6, -1);
    cfg.period = 14'h0005;
    gap(6, 10);
    gap(6, 6);
    gap(6, 6);
  endtask

  // open-loop edges, sub-steps, adjust and polarity
  task automatic t_edges();
    int n;
    cfg = '0;
    cfg.open_loop = 1'b1;
    cfg.period = 14'h0009;
    cfg.event1 = 14'h0002;
    cfg.event2 = {14'h0005, 4'h3};
    cfg.event3 = {14'h0006, 4'h0};
    cfg.event4 = {14'h0008, 4'h7};
    gap(6, -1);
    gap(6, -1);
    tally(0, 10, n);
    chk(n == 3, "A on-time");
    tally(1, 10, n);
    chk(n == 2, "B on-time");
    gap(6, -1);
    step(9);
    chk(sub_a === 4'h3 && sub_b === 4'h7, "fall sub-steps");
    cfg.adj_a = 16'sh0010;
    gap(6, -1);
    tally(0, 10, n);
    chk(n == 4, "A with adjust");
    cfg.pol_low_a = 1'b1;
    gap(6, -1);
    tally(0, 10, n);
    chk(n == 6, "A active low");
    cfg.adj_b = 16'shFFF0;
    cfg.pol_low_b = 1'b1;
    gap(6, -1);
    tally(1, 10, n);
    chk(n == 9, "B adjust and active low");
  endtask

  // sync output position and sync input clearing the timer
  task automatic t_sync();
    cfg.period = 14'h001D;
    cfg.phase = 14'h0004;
    gap(6, -1);
    gap(2, 5);
    step(5);
    sync_in = 1'b1;
    step(1);
    sync_in = 1'b0;
    gap(2, 5);
  endtask

  // sample triggers with every oversampling code, second trigger, blanking
  task automatic t_sample();
    int n;
    cfg.period = 14'h001F;
    cfg.samp1 = 12'h002;
    cfg.samp2 = 12'h005;
    cfg.blank_a_begin = 14'h0003;
    cfg.blank_a_end = 14'h0006;
    cfg.blank_b_begin = 14'h0002;
    cfg.blank_b_end = 14'h0004;
    for (int os = 0; os < 4; os++)
    begin
      cfg.oversample = os[1:0];
      gap(6, -1);
      gap(6, -1);
      tally(3, 32, n);
      chk(n == (1 << os), $sformatf("trigger count code %0d", os));
    end
    gap(6, -1);
    gap(3, 9);
    gap(6, -1);
    gap(4, 21);
    gap(6, -1);
    gap(5, 4);
    gap(6, -1);
    gap(8, 3);
  endtask

  // periodic interrupt divider and its converter start twin
  task automatic t_irq();
    cfg.period = 14'h0009;
    cfg.irq_ratio = 8'h02;
    gap(7, -1);
    gap(7, -1);
    gap(7, 30);
    chk(gp_conv_start === 1'b1, "converter start with interrupt");
    cfg.irq_ratio = 8'h00;
    gap(7, -1);
    gap(7, 10);
  endtask

  // closed loop: duty from the far side sets the A fall, event2 ignored
  task automatic t_loop(input logic signed [DUTY_W-1:0] d, input int exp_n);
    int n;
    cfg = '0;
    cfg.period = 14'h000F;
    cfg.event2 = {14'h0002, 4'h0};
    cfg.samp1 = 12'h001;
    duty_cmd = d;
    repeat (4) gap(6, -1);
    tally(0, 16, n);
    chk(n == exp_n, "closed-loop on-time");
    gap(6, -1);
    step(8);
    if (exp_n > 0)
      chk(sub_a === 4'h8, "closed-loop sub-step");
  endtask

  initial
  begin
    step(16);
    chk(output_a === 1'b0 && period_end === 1'b0, "outputs in reset");
    srst = 1'b0;
    t_period();
    t_edges();
    t_sync();
    t_sample();
    t_irq();
    t_loop(24'sh400000, 7);
    t_loop(-24'sh100000, 0);
    wrap_up();
  end
endmodule
